// ---- pfs_map.svh ----
// Register offsets, field positions, reset values and presets of the pin function select block
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// ==========================================
// Register offsets
`define PFS_OFS_SETUP 8'h00
`define PFS_OFS_SEL1 8'h01
`define PFS_OFS_SEL2 8'h02
`define PFS_OFS_SEL3 8'h03
`define PFS_OFS_SEL4 8'h04
`define PFS_OFS_EASY 8'h14

// ==========================================
// Field positions
`define PFS_B_SETUP_DONE 5
`define PFS_B1_VID 7
`define PFS_B1_DIODE1 6
`define PFS_B1_DIODE3 5
`define PFS_B1_FAN1 4
`define PFS_B1_FAN5 0
`define PFS_B2_FAN6 7
`define PFS_B2_DRIVE4 6
`define PFS_B2_FAN7 3
`define PFS_B2_FAN8 2
`define PFS_B3_HOT1 5
`define PFS_B3_HOT2 3
`define PFS_B3_INTR 1
`define PFS_B4_THERM1 7
`define PFS_B4_THERM2 5
`define PFS_B4_DRIVE1 3
`define PFS_B4_DRIVE2 2

// ==========================================
// Field codes
`define PFS_CODE_A 2'h0
`define PFS_CODE_B 2'h1
`define PFS_CODE_C 2'h2

// ==========================================
// Pad positions in the multifunction pad vector
`define PFS_PAD_FAN5 4
`define PFS_PAD_FAN6 5
`define PFS_PAD_DRIVE4 6
`define PFS_PAD_FAN7 7
`define PFS_PAD_FAN8 8
`define PFS_PAD_HOT1 9
`define PFS_PAD_HOT2 10
`define PFS_PAD_INTR 11
`define PFS_PAD_THERM1 12
`define PFS_PAD_THERM2 13
`define PFS_PAD_DRIVE1 14
`define PFS_PAD_DRIVE2 15

// ==========================================
// Reset values and presets (preset one is the reset state)
`define PFS_RST_SETUP 8'h00
`define PFS_RST_EASY 8'h00
`define PFS_P1_SEL1 8'h7F
`define PFS_P1_SEL2 8'hCE
`define PFS_P1_SEL3 8'h42
`define PFS_P1_SEL4 8'hAC
`define PFS_P2_SEL1 8'h7F
`define PFS_P2_SEL2 8'hCC
`define PFS_P2_SEL3 8'h28
`define PFS_P2_SEL4 8'hAC
`define PFS_P3_SEL1 8'h1E
`define PFS_P3_SEL2 8'h00
`define PFS_P3_SEL3 8'h12
`define PFS_P3_SEL4 8'h5C
`define PFS_P4_SEL1 8'h5F
`define PFS_P4_SEL2 8'hC0
`define PFS_P4_SEL3 8'h60
`define PFS_P4_SEL4 8'hAC
`define PFS_P5_SEL1 8'h3E
`define PFS_P5_SEL2 8'h0E
`define PFS_P5_SEL3 8'h18
`define PFS_P5_SEL4 8'hAC

// ==========================================
// Channel count and last channel index
`define PFS_NCHAN 18
`define PFS_LAST_CHAN 5'h11

`endif

// ---- pfs_pkg.sv ----
// Types of the pin function select block
package pfs_pkg;

  // ==========================================
  // Pin function select registers
  typedef struct packed {
    logic [7:0] sel1;
    logic [7:0] sel2;
    logic [7:0] sel3;
    logic [7:0] sel4;
  } pfs_cfg_s;

  // ==========================================
  // Decoded functional inputs
  typedef struct packed {
    logic [7:0] fan_speed;
    logic [6:0] voltage_id;
    logic [1:0] thermal_io;
    logic [1:0] general_io;
    logic reg_hot_one;
    logic reg_hot_two;
    logic intrusion;
    logic force_full;
  } pfs_func_s;

  // ==========================================
  // Monitoring sequencer states
  typedef enum logic [1:0] {
    PFS_WAIT = 2'h0,
    PFS_SCAN = 2'h1,
    PFS_CONV = 2'h3
  } pfs_seq_e;

endpackage

// ---- pfs_pin_select.sv ----
// Pin function select: configuration registers, pad routing, monitoring sequencer
`timescale 1ns/1ps
`include "pfs_map.svh"
// Function
// - Select one bit 0: fan speed input five, else twelve-volt monitor one.
// - Select two bit 7: fan speed input six, else twelve-volt monitor two.
// - Select two bit 6: fan drive four, else 3.3 volt monitor.
// - Select one bit 6: remote diode one, else supply and termination monitor one.
// - Select one bit 5: remote diode three, else 0.9 volt and termination two.
// - Select two bits 3, 2: fan speed seven, eight, else five and twelve volt.
// - Select two field 1:0: core supply one at 00, 1.8 volt at 10.
// - Select three field 7:6: core supply two at 00, 2.5 volt at 01.
// - Select three field 5:4: 1.2 volt at 01, upper bit set is hot one.
// - Select three field 3:2: battery at 00, upper bit set is hot two.
// - Select three bit 1: intrusion input, else force fans full input.
// - Select four fields 7:6, 5:4 at 01: 1.5 volt or general I/O.
// - Select four bits 3, 2 enable fan drives one and two.
// - Select one bit 7 turns several pins into voltage-ID inputs, overriding all.
// - Monitoring starts only after software sets the setup-complete bit.
// - Easy configuration bits 0 to 4 load presets one to five.
module pfs_pin_select
  import pfs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe_out,
  input wire logic [3:0] fan_drive_in,
  input wire logic [1:0] thermal_assert_in,
  input wire logic [1:0] gpio_data_in,
  input wire logic [1:0] gpio_oe_in,
  output pfs_pkg::pfs_func_s func_out,
  output pfs_pkg::pfs_cfg_s cfg_out,
  output logic [17:0] chan_enable_out,
  output logic conv_req_out,
  output logic [4:0] conv_chan_out,
  input wire logic conv_done_in,
  output logic result_wr_out
);
  import pfs_pkg::*;

  // ==========================================
  // State record
  typedef struct packed {
    pfs_cfg_s cfg;
    logic [7:0] setup;
    logic [7:0] easy;
    logic [7:0] rdata;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] pout;
    logic [15:0] poe;
    pfs_func_s func;
    pfs_seq_e seq;
    logic [4:0] chan;
  } pfs_state_s;

  pfs_state_s s_r;
  pfs_state_s s_nxt;
  logic rst_meta_r;
  logic rst_sync_r;
  logic vid_on;
  logic setup_done;
  logic therm1_sel;
  logic therm2_sel;
  logic [17:0] chan_en;

  // ==========================================
  // Reset release through two flops
  // Assertion stays asynchronous; only the release is retimed
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================
  // Selection decode
  // Voltage-ID mode wins over every other use of its pads
  assign vid_on = s_r.cfg.sel1[`PFS_B1_VID];
  assign setup_done = s_r.setup[`PFS_B_SETUP_DONE];
  assign therm1_sel = s_r.cfg.sel4[`PFS_B4_THERM1] & ~vid_on;
  assign therm2_sel = s_r.cfg.sel4[`PFS_B4_THERM2];

  // Measuring channels: 0 local temperature, 1 to 17 pin channels
  // A channel left out here is skipped and never stored
  always_comb
  begin
    chan_en = '0;
    chan_en[0] = 1'b1;
    chan_en[1] = s_r.cfg.sel1[`PFS_B1_DIODE1];
    chan_en[2] = s_r.cfg.sel1[`PFS_B1_DIODE3];
    chan_en[3] = ~s_r.cfg.sel1[`PFS_B1_FAN5];
    chan_en[4] = ~s_r.cfg.sel2[`PFS_B2_FAN6];
    chan_en[5] = ~s_r.cfg.sel2[`PFS_B2_DRIVE4];
    chan_en[6] = ~s_r.cfg.sel1[`PFS_B1_DIODE1];
    chan_en[7] = ~s_r.cfg.sel1[`PFS_B1_DIODE1];
    chan_en[8] = ~s_r.cfg.sel1[`PFS_B1_DIODE3];
    chan_en[9] = ~s_r.cfg.sel1[`PFS_B1_DIODE3];
    chan_en[10] = ~s_r.cfg.sel2[`PFS_B2_FAN7];
    chan_en[11] = ~s_r.cfg.sel2[`PFS_B2_FAN8];
    chan_en[12] = (s_r.cfg.sel2[1:0] == `PFS_CODE_A)
      | (s_r.cfg.sel2[1:0] == `PFS_CODE_C);
    chan_en[13] = (s_r.cfg.sel3[7:6] == `PFS_CODE_A)
      | (s_r.cfg.sel3[7:6] == `PFS_CODE_B);
    chan_en[14] = ~s_r.cfg.sel3[`PFS_B3_HOT1];
    chan_en[15] = ~s_r.cfg.sel3[`PFS_B3_HOT2];
    chan_en[16] = (s_r.cfg.sel4[7:6] == `PFS_CODE_B) & ~vid_on;
    chan_en[17] = (s_r.cfg.sel4[5:4] == `PFS_CODE_B);
  end

  // ==========================================
  // Next-state logic
  always_comb
  begin
    s_nxt = s_r;

    // Pad synchronisers
    // Pads are asynchronous; only the second flop feeds the decode
    s_nxt.sync1 = pad_in;
    s_nxt.sync2 = s_r.sync1;

    // Register writes
    // Unmapped addresses are dropped
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        `PFS_OFS_SETUP: s_nxt.setup = reg_wdata_in;
        `PFS_OFS_SEL1: s_nxt.cfg.sel1 = reg_wdata_in;
        `PFS_OFS_SEL2: s_nxt.cfg.sel2 = reg_wdata_in;
        `PFS_OFS_SEL3: s_nxt.cfg.sel3 = reg_wdata_in;
        `PFS_OFS_SEL4: s_nxt.cfg.sel4 = reg_wdata_in;
        `PFS_OFS_EASY:
        begin
          s_nxt.easy = reg_wdata_in;
          // Lowest set option bit wins
          // Single fields may still be rewritten afterwards
          if (reg_wdata_in[0])
            s_nxt.cfg = {`PFS_P1_SEL1, `PFS_P1_SEL2, `PFS_P1_SEL3, `PFS_P1_SEL4};
          else if (reg_wdata_in[1])
            s_nxt.cfg = {`PFS_P2_SEL1, `PFS_P2_SEL2, `PFS_P2_SEL3, `PFS_P2_SEL4};
          else if (reg_wdata_in[2])
            s_nxt.cfg = {`PFS_P3_SEL1, `PFS_P3_SEL2, `PFS_P3_SEL3, `PFS_P3_SEL4};
          else if (reg_wdata_in[3])
            s_nxt.cfg = {`PFS_P4_SEL1, `PFS_P4_SEL2, `PFS_P4_SEL3, `PFS_P4_SEL4};
          else if (reg_wdata_in[4])
            s_nxt.cfg = {`PFS_P5_SEL1, `PFS_P5_SEL2, `PFS_P5_SEL3, `PFS_P5_SEL4};
        end
        default: ;
      endcase
    end

    // Read data, one cycle after the address
    // Unmapped addresses read as zero
    case (reg_addr_in)
      `PFS_OFS_SETUP: s_nxt.rdata = s_r.setup;
      `PFS_OFS_SEL1: s_nxt.rdata = s_r.cfg.sel1;
      `PFS_OFS_SEL2: s_nxt.rdata = s_r.cfg.sel2;
      `PFS_OFS_SEL3: s_nxt.rdata = s_r.cfg.sel3;
      `PFS_OFS_SEL4: s_nxt.rdata = s_r.cfg.sel4;
      `PFS_OFS_EASY: s_nxt.rdata = s_r.easy;
      default: s_nxt.rdata = 8'h00;
    endcase

    // Fan speed inputs from their pads
    s_nxt.func.fan_speed[3:0] = s_r.sync2[3:0] & s_r.cfg.sel1[`PFS_B1_FAN1 -: 4]
      & {4{~vid_on}};
    s_nxt.func.fan_speed[4] = s_r.sync2[`PFS_PAD_FAN5] & s_r.cfg.sel1[`PFS_B1_FAN5];
    s_nxt.func.fan_speed[5] = s_r.sync2[`PFS_PAD_FAN6] & s_r.cfg.sel2[`PFS_B2_FAN6];
    s_nxt.func.fan_speed[6] = s_r.sync2[`PFS_PAD_FAN7] & s_r.cfg.sel2[`PFS_B2_FAN7];
    s_nxt.func.fan_speed[7] = s_r.sync2[`PFS_PAD_FAN8] & s_r.cfg.sel2[`PFS_B2_FAN8];

    // Voltage-ID inputs take over seven pads
    if (vid_on)
      s_nxt.func.voltage_id = {s_r.sync2[`PFS_PAD_DRIVE2], s_r.sync2[`PFS_PAD_DRIVE1],
        s_r.sync2[`PFS_PAD_THERM1], s_r.sync2[3:0]};
    else
      s_nxt.func.voltage_id = 7'h00;

    // Regulator hot, intrusion and force-full inputs
    s_nxt.func.reg_hot_one = s_r.sync2[`PFS_PAD_HOT1] & s_r.cfg.sel3[`PFS_B3_HOT1];
    s_nxt.func.reg_hot_two = s_r.sync2[`PFS_PAD_HOT2] & s_r.cfg.sel3[`PFS_B3_HOT2];
    s_nxt.func.intrusion = s_r.sync2[`PFS_PAD_INTR] & s_r.cfg.sel3[`PFS_B3_INTR];
    s_nxt.func.force_full = s_r.sync2[`PFS_PAD_INTR] & ~s_r.cfg.sel3[`PFS_B3_INTR];

    // Thermal and general I/O inputs
    s_nxt.func.thermal_io = {s_r.sync2[`PFS_PAD_THERM2] & therm2_sel,
      s_r.sync2[`PFS_PAD_THERM1] & therm1_sel};
    s_nxt.func.general_io = {s_r.sync2[`PFS_PAD_THERM2] & ~therm2_sel,
      s_r.sync2[`PFS_PAD_THERM1] & ~s_r.cfg.sel4[`PFS_B4_THERM1] & ~vid_on};

    // Pad drivers: all released unless a function drives
    s_nxt.pout = 16'h0000;
    s_nxt.poe = 16'h0000;
    s_nxt.pout[`PFS_PAD_DRIVE4] = fan_drive_in[3];
    s_nxt.poe[`PFS_PAD_DRIVE4] = s_r.cfg.sel2[`PFS_B2_DRIVE4];
    s_nxt.pout[`PFS_PAD_DRIVE1] = fan_drive_in[0];
    s_nxt.poe[`PFS_PAD_DRIVE1] = s_r.cfg.sel4[`PFS_B4_DRIVE1] & ~vid_on;
    s_nxt.pout[`PFS_PAD_DRIVE2] = fan_drive_in[1];
    s_nxt.poe[`PFS_PAD_DRIVE2] = s_r.cfg.sel4[`PFS_B4_DRIVE2] & ~vid_on;

    // Thermal pins pull low only; general I/O drives when enabled
    // Mixed thermal and 1.5 volt settings are left to software
    if (therm1_sel)
      s_nxt.poe[`PFS_PAD_THERM1] = thermal_assert_in[0];
    else if (!vid_on)
    begin
      s_nxt.pout[`PFS_PAD_THERM1] = gpio_data_in[0];
      s_nxt.poe[`PFS_PAD_THERM1] = gpio_oe_in[0];
    end
    if (therm2_sel)
      s_nxt.poe[`PFS_PAD_THERM2] = thermal_assert_in[1];
    else
    begin
      s_nxt.pout[`PFS_PAD_THERM2] = gpio_data_in[1];
      s_nxt.poe[`PFS_PAD_THERM2] = gpio_oe_in[1];
    end

    // Monitoring sequencer
    // Clearing setup abandons a running conversion at once
    // Each disabled channel costs one scan cycle
    case (s_r.seq)
      PFS_WAIT:
      begin
        s_nxt.chan = 5'h00;
        if (setup_done)
          s_nxt.seq = PFS_SCAN;
      end
      PFS_SCAN:
      begin
        if (!setup_done)
          s_nxt.seq = PFS_WAIT;
        else if (chan_en[s_r.chan])
          s_nxt.seq = PFS_CONV;
        else if (s_r.chan == `PFS_LAST_CHAN)
          s_nxt.chan = 5'h00;
        else
          s_nxt.chan = s_r.chan + 5'h01;
      end
      PFS_CONV:
      begin
        if (!setup_done)
          s_nxt.seq = PFS_WAIT;
        else if (conv_done_in)
        begin
          s_nxt.seq = PFS_SCAN;
          if (s_r.chan == `PFS_LAST_CHAN)
            s_nxt.chan = 5'h00;
          else
            s_nxt.chan = s_r.chan + 5'h01;
        end
      end
      default:
        s_nxt.seq = PFS_WAIT;
    endcase
  end

  // ==========================================
  // State register
  // Reset value is preset one, so every pin starts in a known use
  always_ff @(posedge core_clk_in or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      s_r <= '0;
      s_r.cfg <= {`PFS_P1_SEL1, `PFS_P1_SEL2, `PFS_P1_SEL3, `PFS_P1_SEL4};
      s_r.setup <= `PFS_RST_SETUP;
      s_r.easy <= `PFS_RST_EASY;
      s_r.seq <= PFS_WAIT;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================
  // Outputs
  // Handshake outputs decode the state directly; data comes from flops
  assign reg_rdata_out = s_r.rdata;
  assign pad_out = s_r.pout;
  assign pad_oe_out = s_r.poe;
  assign func_out = s_r.func;
  assign cfg_out = s_r.cfg;
  assign chan_enable_out = chan_en & {`PFS_NCHAN{setup_done}};
  assign conv_req_out = (s_r.seq == PFS_CONV);
  assign conv_chan_out = s_r.chan;
  // Result written only for a channel still measuring
  assign result_wr_out = conv_done_in & (s_r.seq == PFS_CONV)
    & chan_en[s_r.chan] & setup_done;

endmodule

// ---- pfs_pin_select_checker.sv ----
// Concurrent checks on the ports of the pin function select block
`timescale 1ns/1ps
`include "pfs_map.svh"
module pfs_pin_select_checker
  import pfs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [3:0] fan_drive_in,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe_out,
  input wire pfs_pkg::pfs_func_s func_out,
  input wire pfs_pkg::pfs_cfg_s cfg_out,
  input wire logic [17:0] chan_enable_out,
  input wire logic conv_req_out,
  input wire logic [4:0] conv_chan_out,
  input wire logic conv_done_in,
  input wire logic result_wr_out
);
  import pfs_pkg::*;

  // ==========================================
  // Helpers: settle time after reset, shadow of the setup bit
  logic [3:0] live_r;
  logic setup_r;

  // Outputs are trusted only once the reset synchroniser has drained
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      live_r <= 4'h0;
      setup_r <= 1'b0;
    end
    else
    begin
      live_r <= {live_r[2:0], 1'b1};
      if (reg_wr_in && reg_addr_in == `PFS_OFS_SETUP)
        setup_r <= reg_wdata_in[`PFS_B_SETUP_DONE];
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in || !live_r[3]);

  // ==========================================
  // Assertions
  property p_fan5_off;
    $past(!cfg_out.sel1[0]) |-> !func_out.fan_speed[4];
  endproperty
  a_fan5_off: assert property (p_fan5_off) else $error("fan five seen while off");

  property p_drive4;
    $past(cfg_out.sel2[6]) |-> pad_oe_out[6] && pad_out[6] == $past(fan_drive_in[3]);
  endproperty
  a_drive4: assert property (p_drive4) else $error("drive four not on its pad");

  property p_hot1_off;
    $past(!cfg_out.sel3[5]) |-> !func_out.reg_hot_one;
  endproperty
  a_hot1_off: assert property (p_hot1_off) else $error("hot one seen while off");

  property p_intr_excl;
    $past(cfg_out.sel3[1]) |-> !func_out.force_full;
  endproperty
  a_intr_excl: assert property (p_intr_excl) else $error("force full seen");

  property p_drive1;
    $past(cfg_out.sel4[3] && !cfg_out.sel1[7])
      |-> pad_oe_out[14] && pad_out[14] == $past(fan_drive_in[0]);
  endproperty
  a_drive1: assert property (p_drive1) else $error("drive one not on its pad");

  property p_vid_over;
    $past(cfg_out.sel1[7]) |-> pad_oe_out[15:14] == 2'b00 && func_out.fan_speed[3:0] == 4'h0;
  endproperty
  a_vid_over: assert property (p_vid_over) else $error("voltage id not overriding");

  property p_idle;
    !setup_r && !$past(setup_r) |-> !conv_req_out && chan_enable_out == 18'h00000;
  endproperty
  a_idle: assert property (p_idle) else $error("monitoring before setup");

  property p_hold;
    conv_req_out && !conv_done_in |=> !setup_r || (conv_req_out && $stable(conv_chan_out));
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");

  property p_store;
    result_wr_out |-> conv_req_out && conv_done_in && chan_enable_out[conv_chan_out];
  endproperty
  a_store: assert property (p_store) else $error("result stored without cause");
endmodule

bind pfs_pin_select pfs_pin_select_checker u_chk (.core_clk_in, .rst_b_in, .reg_wr_in,
  .reg_addr_in, .reg_wdata_in, .fan_drive_in, .pad_out, .pad_oe_out, .func_out, .cfg_out,
  .chan_enable_out, .conv_req_out, .conv_chan_out, .conv_done_in, .result_wr_out);

// ---- pfs_pin_select_tb.sv ----
// Self-checking testbench of the pin function select block
`timescale 1ns/1ps
`include "pfs_map.svh"
module pfs_pin_select_tb;
  import pfs_pkg::*;
  logic core_clk_in, rst_b_in, reg_wr_in, conv_done_in, conv_req_out, result_wr_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [15:0] pad_in, pad_out, pad_oe_out;
  logic [3:0] fan_drive_in;
  logic [1:0] thermal_assert_in, gpio_data_in, gpio_oe_in;
  logic [17:0] chan_enable_out;
  logic [4:0] conv_chan_out;
  pfs_func_s func_out;
  pfs_cfg_s cfg_out;
  int failures, n_compared, k;
  logic [31:0] presets [5] = '{{`PFS_P1_SEL1, `PFS_P1_SEL2, `PFS_P1_SEL3, `PFS_P1_SEL4},
    {`PFS_P2_SEL1, `PFS_P2_SEL2, `PFS_P2_SEL3, `PFS_P2_SEL4},
    {`PFS_P3_SEL1, `PFS_P3_SEL2, `PFS_P3_SEL3, `PFS_P3_SEL4},
    {`PFS_P4_SEL1, `PFS_P4_SEL2, `PFS_P4_SEL3, `PFS_P4_SEL4},
    {`PFS_P5_SEL1, `PFS_P5_SEL2, `PFS_P5_SEL3, `PFS_P5_SEL4}};
  logic [4:0] seq_exp [8] = '{5'h00, 5'h01, 5'h02, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h00};

  pfs_pin_select u_dut (.core_clk_in, .rst_b_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .pad_in, .pad_out, .pad_oe_out, .fan_drive_in, .thermal_assert_in,
    .gpio_data_in, .gpio_oe_in, .func_out, .cfg_out, .chan_enable_out, .conv_req_out,
    .conv_chan_out, .conv_done_in, .result_wr_out);

  // ==========================================
  // Clock and watchdog (tests need well under 2000 cycles)
  initial
  begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  initial
  begin
    #20000;
    failures++;
    final_report();
  end

  // ==========================================
  // Access tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One write strobe, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    tick(1);
    reg_wr_in = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_in = a;
    tick(2);
    chk(reg_rdata_out, exp);
  endtask

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // Test sequence
  initial
  begin
    failures = 0;
    n_compared = 0;
    rst_b_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    pad_in = 16'hFFFF;
    fan_drive_in = 4'h9;
    thermal_assert_in = 2'h2;
    gpio_data_in = 2'h1;
    gpio_oe_in = 2'h0;
    conv_done_in = 1'b0;
    tick(12);
    rst_b_in = 1'b1;
    tick(3);
    // Reset state, unmapped address
    chk(cfg_out, presets[0]);
    rd(`PFS_OFS_SEL3, `PFS_P1_SEL3);
    wr(8'h55, 8'hA5);
    rd(8'h55, 8'h00);
    $display("Test reset done");
    // Presets, lowest bit wins, fields still writable
    for (int i = 0; i < 5; i++)
    begin
      wr(`PFS_OFS_EASY, 8'h01 << i);
      chk(cfg_out, presets[i]);
    end
    rd(`PFS_OFS_EASY, 8'h10);
    wr(`PFS_OFS_EASY, 8'h0A);
    chk(cfg_out, presets[1]);
    wr(`PFS_OFS_SEL4, 8'h5C);
    rd(`PFS_OFS_SEL4, 8'h5C);
    $display("Test presets done");
    // Fan speed inputs and voltage-id override
    wr(`PFS_OFS_SEL1, 8'h1F);
    wr(`PFS_OFS_SEL2, 8'h8C);
    wr(`PFS_OFS_SEL4, 8'hAC);
    tick(4);
    chk(func_out.fan_speed, 8'hFF);
    wr(`PFS_OFS_SEL1, 8'h1E);
    wr(`PFS_OFS_SEL2, 8'h00);
    tick(4);
    chk(func_out.fan_speed, 8'h0F);
    pad_in = 16'hFFF0;
    tick(4);
    chk(func_out.fan_speed, 8'h00);
    pad_in = 16'hFFFF;
    wr(`PFS_OFS_SEL1, 8'h9E);
    tick(4);
    chk(func_out.fan_speed, 8'h00);
    chk(func_out.voltage_id, 7'h7F);
    chk(pad_oe_out[15:14], 2'b00);
    $display("Test inputs done");
    // Fan drives, thermal open drain, general I/O
    wr(`PFS_OFS_SEL1, 8'h1E);
    wr(`PFS_OFS_SEL2, 8'h40);
    tick(2);
    chk({pad_oe_out[15:12], pad_oe_out[6]}, 5'b11101);
    chk({pad_out[15:12], pad_out[6]}, 5'b01001);
    chk({func_out.general_io, func_out.thermal_io}, 4'h3);
    fan_drive_in = 4'h6;
    tick(2);
    chk({pad_out[15:14], pad_out[6]}, 3'b100);
    wr(`PFS_OFS_SEL2, 8'h00);
    wr(`PFS_OFS_SEL4, 8'h50);
    tick(4);
    chk({pad_oe_out[15:12], pad_oe_out[6]}, 5'b00000);
    chk({func_out.general_io, func_out.thermal_io}, 4'hC);
    $display("Test outputs done");
    // Regulator-hot, battery, intrusion and force-full
    wr(`PFS_OFS_SEL3, 8'h28);
    tick(4);
    chk({func_out.reg_hot_one, func_out.reg_hot_two, func_out.intrusion,
      func_out.force_full}, 4'hD);
    wr(`PFS_OFS_SEL3, 8'h12);
    tick(4);
    chk({func_out.reg_hot_one, func_out.reg_hot_two, func_out.intrusion,
      func_out.force_full}, 4'h2);
    $display("Test sel3 done");
    // Monitoring sequence on preset one
    wr(`PFS_OFS_EASY, 8'h01);
    conv_done_in = 1'b1;
    #1;
    chk({result_wr_out, chan_enable_out}, 19'h00000);
    tick(1);
    conv_done_in = 1'b0;
    wr(`PFS_OFS_SETUP, 8'h20);
    chk(chan_enable_out, 18'h0F007);
    foreach (seq_exp[i])
    begin
      k = 0;
      while (conv_req_out !== 1'b1 && k < 40)
      begin
        tick(1);
        k++;
      end
      chk(conv_chan_out, seq_exp[i]);
      conv_done_in = 1'b1;
      #1;
      chk(result_wr_out, 1'b1);
      tick(1);
      conv_done_in = 1'b0;
    end
    // Channel one dropped while converting: result must not be stored
    tick(1);
    wr(`PFS_OFS_SEL1, 8'h3F);
    chk({conv_req_out, conv_chan_out}, 6'h21);
    conv_done_in = 1'b1;
    #1;
    chk(result_wr_out, 1'b0);
    tick(1);
    conv_done_in = 1'b0;
    wr(`PFS_OFS_SETUP, 8'h00);
    tick(2);
    chk({conv_req_out, chan_enable_out}, 19'h00000);
    $display("Test sequence done");
    final_report();
  end
endmodule
